// ===== hw/eca_defines.svh
// Contract
// - Write programs data register byte at address; read loads stored byte into data register.
// - Control register bits 7..4 always read as zero.
// - Ready interrupt held while enable, global interrupt set and write strobe reads zero.
// - Master write enable clears itself four clock cycles after software sets it.
// - Write strobe without master write enable changes nothing, starts no programming.
// - Write strobe within the master enable window starts programming selected address.
// - No data programming proceeds while program memory store is active.
// - Write strobe reads one during programming, cleared by hardware when done.
// - Setting write strobe stalls the CPU for two cycles.
// - Read strobe reads addressed byte at once and stalls CPU four cycles.
// - During programming, reads are ignored and address register cannot change.
// - Programming time is 67584 calibrated oscillator cycles, typically 8.5 ms.
// - A reset during programming lets the programming cycle complete.
// - Address register is twelve bits; upper bits read zero; load before use.
`ifndef ECA_DEFINES_SVH
`define ECA_DEFINES_SVH

// ----------------------------------------
// Register select codes
// ----------------------------------------
`define ECA_SEL_ADDR_LO   2'h0
`define ECA_SEL_ADDR_HI   2'h1
`define ECA_SEL_DATA      2'h2
`define ECA_SEL_CTRL      2'h3

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define ECA_BIT_READ      0
`define ECA_BIT_WSTROBE   1
`define ECA_BIT_MWE       2
`define ECA_BIT_RIE       3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ECA_DATA_RESET    8'h00
`define ECA_ADDR_RESET    12'h000

// ----------------------------------------
// Timing
// ----------------------------------------
`define ECA_MWE_CYCLES    3'h4
`define ECA_RD_STALL      3'h4
`define ECA_WR_STALL      3'h2
`define ECA_PROG_RC_CYCLES 67584
`define ECA_PROG_TIME_US  8500

`endif

// ===== hw/eca_pkg.sv
package eca_pkg;

    // Register select on the I/O port
    typedef logic [1:0] eca_sel_type;

    // Programming engine
    typedef enum logic [1:0] {
        PROG_IDLE,
        PROG_RUN,
        PROG_COMMIT
    } eca_prog_state_type;

endpackage

// ===== hw/eca_mem.sv
`timescale 1ns/10ps
module eca_mem #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 12,
    parameter int DEPTH  = 4096
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Write port
    input  wire logic              wrEn,
    input  wire logic [ADDR_W-1:0] wrAddr,
    input  wire logic [DATA_W-1:0] wrData,
    // Read port
    input  wire logic              rdEn,
    input  wire logic [ADDR_W-1:0] rdAddr,
    output logic      [DATA_W-1:0] rdData_q
);

    logic [DATA_W-1:0] store [DEPTH];

    // Array has no reset; contents survive any reset
    always_ff @(posedge clk) begin
        if (wrEn) begin
            store[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdData_q <= '0;
        end else if (rdEn) begin
            rdData_q <= store[rdAddr];
        end
    end

endmodule

// ===== hw/eca_top.sv
`timescale 1ns/10ps
`include "eca_defines.svh"
module eca_top #(
    parameter int ADDR_W         = 12,
    parameter int MEM_DEPTH      = 4096,
    parameter int PROG_RC_CYCLES = `ECA_PROG_RC_CYCLES
) (
    // Clock and resets
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               porRst,
    // CPU I/O register port
    input  wire logic               ioWrite,
    input  wire logic               ioRead,
    input  wire eca_pkg::eca_sel_type ioSel,
    input  wire logic [7:0]         ioWdata,
    output logic      [7:0]         ioRdata_q,
    // CPU side status
    input  wire logic               globalIrqEnable,
    input  wire logic               programStoreEnable,
    output logic                    readyIrq,
    output logic                    cpuStall,
    // Calibrated oscillator pin
    input  wire logic               rcClkPin
);
    import eca_pkg::*;

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic logic selHit(input logic strobe, input eca_sel_type sel,
                                    input eca_sel_type code);
        selHit = strobe && (sel == code);
    endfunction

    localparam int CNT_W = $clog2(PROG_RC_CYCLES + 1);
    localparam logic [CNT_W-1:0] PROG_LAST = CNT_W'(PROG_RC_CYCLES - 1);

    logic              wrAddrLo;
    logic              wrAddrHi;
    logic              wrData;
    logic              wrCtrl;
    logic              rdAny;

    assign wrAddrLo = selHit(ioWrite, ioSel, `ECA_SEL_ADDR_LO);
    assign wrAddrHi = selHit(ioWrite, ioSel, `ECA_SEL_ADDR_HI);
    assign wrData   = selHit(ioWrite, ioSel, `ECA_SEL_DATA);
    assign wrCtrl   = selHit(ioWrite, ioSel, `ECA_SEL_CTRL);
    assign rdAny    = ioRead;

    // ----------------------------------------
    // State declarations
    // ----------------------------------------
    logic [ADDR_W-1:0]  addr_q;
    logic [7:0]         data_q;
    logic               rie_q;
    logic [2:0]         mweCnt_q;
    logic [2:0]         stallCnt_q;
    logic               rdPend_q;
    eca_prog_state_type progState_q;
    logic [CNT_W-1:0]   progCnt_q;
    logic [ADDR_W-1:0]  latAddr_q;
    logic [7:0]         latData_q;
    logic               rcSync1_q;
    logic               rcSync2_q;
    logic               rcSync3_q;

    logic               busy;
    logic               mweActive;
    logic               startReq;
    logic               readReq;
    logic               rcTick;
    logic               memWrEn;
    logic [7:0]         memRdata;
    logic [7:0]         ctrlView;
    logic [15:0]        addrView;

    // ----------------------------------------
    // Engine status and strobe acceptance
    // ----------------------------------------
    assign busy      = (progState_q != PROG_IDLE);
    assign mweActive = (mweCnt_q != 3'h0);

    // Strobe needs an open enable window and an idle engine
    assign startReq = wrCtrl && ioWdata[`ECA_BIT_WSTROBE] && mweActive && !busy;
    // Reads are dropped while programming
    assign readReq  = wrCtrl && ioWdata[`ECA_BIT_READ] && !busy;

    // ----------------------------------------
    // Oscillator synchroniser
    // ----------------------------------------
    // Third stage only feeds the edge detect; first stage is read by the second alone
    always_ff @(posedge clk or posedge porRst) begin
        if (porRst) begin
            rcSync1_q <= 1'b0;
            rcSync2_q <= 1'b0;
            rcSync3_q <= 1'b0;
        end else begin
            rcSync1_q <= rcClkPin;
            rcSync2_q <= rcSync1_q;
            rcSync3_q <= rcSync2_q;
        end
    end

    assign rcTick = rcSync2_q && !rcSync3_q;

    // ----------------------------------------
    // Address register
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_q <= ADDR_W'(`ECA_ADDR_RESET);
        end else if (!busy) begin
            if (wrAddrLo) begin
                addr_q[7:0] <= ioWdata;
            end
            if (wrAddrHi) begin
                addr_q[ADDR_W-1:8] <= ioWdata[ADDR_W-9:0];
            end
        end
    end

    // ----------------------------------------
    // Data register
    // ----------------------------------------
    // Read result wins over a CPU write in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            data_q <= `ECA_DATA_RESET;
        end else if (rdPend_q) begin
            data_q <= memRdata;
        end else if (wrData) begin
            data_q <= ioWdata;
        end
    end

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rie_q <= 1'b0;
        end else if (wrCtrl) begin
            rie_q <= ioWdata[`ECA_BIT_RIE];
        end
    end

    // ----------------------------------------
    // Master write enable window
    // ----------------------------------------
    // Window counts down and drops itself; a strobe closes it early
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mweCnt_q <= 3'h0;
        end else if (wrCtrl && ioWdata[`ECA_BIT_MWE]) begin
            mweCnt_q <= `ECA_MWE_CYCLES;
        end else if (startReq) begin
            mweCnt_q <= 3'h0;
        end else if (mweActive) begin
            mweCnt_q <= mweCnt_q - 3'h1;
        end
    end

    // ----------------------------------------
    // Read strobe
    // ----------------------------------------
    // Read strobe is a single-cycle flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdPend_q <= 1'b0;
        end else begin
            rdPend_q <= readReq;
        end
    end

    // ----------------------------------------
    // CPU stall
    // ----------------------------------------
    // Read stall wins when both strobes land in one write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stallCnt_q <= 3'h0;
        end else if (readReq) begin
            stallCnt_q <= `ECA_RD_STALL;
        end else if (startReq) begin
            stallCnt_q <= `ECA_WR_STALL;
        end else if (stallCnt_q != 3'h0) begin
            stallCnt_q <= stallCnt_q - 3'h1;
        end
    end

    assign cpuStall = (stallCnt_q != 3'h0);

    // ----------------------------------------
    // Programming engine
    // ----------------------------------------
    // Held only by power-on reset so a system reset cannot abort a write
    always_ff @(posedge clk or posedge porRst) begin
        if (porRst) begin
            progState_q <= PROG_IDLE;
        end else begin
            unique case (progState_q)
                PROG_IDLE: begin
                    if (startReq) begin
                        progState_q <= PROG_RUN;
                    end
                end
                PROG_RUN: begin
                    if (rcTick && !programStoreEnable && progCnt_q == PROG_LAST) begin
                        progState_q <= PROG_COMMIT;
                    end
                end
                PROG_COMMIT: begin
                    progState_q <= PROG_IDLE;
                end
                // Unused code falls back to idle rather than locking up
                default: begin
                    progState_q <= PROG_IDLE;
                end
            endcase
        end
    end

    // Counting pauses while the program memory store is busy
    always_ff @(posedge clk or posedge porRst) begin
        if (porRst) begin
            progCnt_q <= '0;
        end else if (progState_q == PROG_IDLE) begin
            progCnt_q <= '0;
        end else if (rcTick && !programStoreEnable) begin
            progCnt_q <= progCnt_q + CNT_W'(1);
        end
    end

    // ----------------------------------------
    // Write latches
    // ----------------------------------------
    // Captured at acceptance; later bus writes cannot disturb a write in flight
    always_ff @(posedge clk or posedge porRst) begin
        if (porRst) begin
            latAddr_q <= '0;
            latData_q <= 8'h00;
        end else if (startReq) begin
            latAddr_q <= addr_q;
            latData_q <= data_q;
        end
    end

    assign memWrEn = (progState_q == PROG_COMMIT);

    // ----------------------------------------
    // Storage array
    // ----------------------------------------
    eca_mem #(
        .DATA_W (8),
        .ADDR_W (ADDR_W),
        .DEPTH  (MEM_DEPTH)
    ) u_mem (
        .clk      (clk),
        .rst      (rst),
        .wrEn     (memWrEn),
        .wrAddr   (latAddr_q),
        .wrData   (latData_q),
        .rdEn     (readReq),
        .rdAddr   (addr_q),
        .rdData_q (memRdata)
    );

    // ----------------------------------------
    // Read back and interrupt
    // ----------------------------------------
    always_comb begin
        ctrlView = 8'h00;
        ctrlView[`ECA_BIT_RIE]     = rie_q;
        ctrlView[`ECA_BIT_MWE]     = mweActive;
        ctrlView[`ECA_BIT_WSTROBE] = busy;
        ctrlView[`ECA_BIT_READ]    = rdPend_q;
    end

    always_comb begin
        addrView = 16'h0000;
        addrView[ADDR_W-1:0] = addr_q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ioRdata_q <= 8'h00;
        end else if (rdAny) begin
            unique case (ioSel)
                `ECA_SEL_ADDR_LO: ioRdata_q <= addrView[7:0];
                `ECA_SEL_ADDR_HI: ioRdata_q <= addrView[15:8];
                `ECA_SEL_DATA:    ioRdata_q <= data_q;
                `ECA_SEL_CTRL:    ioRdata_q <= ctrlView;
            endcase
        end
    end

    // ----------------------------------------
    // Ready interrupt
    // ----------------------------------------
    // Level request; masked here by the CPU's own global bit
    assign readyIrq = rie_q && globalIrqEnable && !busy;

endmodule

// ===== test/eca_top_chk.sv
`timescale 1ns/10ps
`include "eca_defines.svh"
module eca_top_chk #(
    parameter int ADDR_W         = 12,
    parameter int PROG_RC_CYCLES = 4
) (
    // Clock and reset
    input wire logic                 clk,
    input wire logic                 rst,
    // Register port
    input wire logic                 ioWrite,
    input wire logic                 ioRead,
    input wire eca_pkg::eca_sel_type ioSel,
    input wire logic [7:0]           ioWdata,
    input wire logic [7:0]           ioRdata_q,
    // Status
    input wire logic                 globalIrqEnable,
    input wire logic                 readyIrq,
    input wire logic                 cpuStall
);
    import eca_pkg::*;
    logic       ctrlWr;
    logic       ctrlRd;
    logic [2:0] mweAge_q;
    assign ctrlWr = ioWrite && ioSel == `ECA_SEL_CTRL;
    assign ctrlRd = ioRead && ioSel == `ECA_SEL_CTRL;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // Age of the last master enable write
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mweAge_q <= 3'h7;
        end else if (ctrlWr && ioWdata[2]) begin
            mweAge_q <= 3'h1;
        end else if (mweAge_q != 3'h7) begin
            mweAge_q <= mweAge_q + 3'h1;
        end
    end
    AST_CTRL_RSVD: assert property (ctrlRd |=> ioRdata_q[7:4] == 4'h0)
        else $error("Control upper bits not zero");
    AST_ADDR_HI_ZERO:
        assert property (ioRead && ioSel == `ECA_SEL_ADDR_HI |=> ioRdata_q[7:4] == 4'h0)
        else $error("Address high upper bits not zero");
    AST_IRQ_GATE: assert property (readyIrq |-> globalIrqEnable)
        else $error("Ready interrupt without global enable");
    AST_RDATA_HOLD: assert property (!ioRead |=> $stable(ioRdata_q))
        else $error("Read data changed without a read");
    AST_STALL_MAX: assert property (cpuStall [*4] |=> !cpuStall)
        else $error("Stall longer than four cycles");
    AST_STALL_MIN: assert property ($rose(cpuStall) |-> cpuStall ##1 cpuStall)
        else $error("Stall shorter than two cycles");
    AST_STALL_CAUSE: assert property ($rose(cpuStall) |-> $past(ctrlWr))
        else $error("Stall without a control write");
    AST_NO_STALL_PLAIN:
        assert property (ctrlWr && ioWdata[1:0] == 2'h0 && !cpuStall |=> !cpuStall)
        else $error("Stall without a strobe");
    AST_MWE_CLEAR: assert property (ctrlRd && mweAge_q >= 3'h5 |=> !ioRdata_q[2])
        else $error("Master enable still set after window");
endmodule
bind eca_top eca_top_chk #(.ADDR_W(ADDR_W), .PROG_RC_CYCLES(PROG_RC_CYCLES)) u_chk (
    .clk(clk), .rst(rst), .ioWrite(ioWrite), .ioRead(ioRead), .ioSel(ioSel),
    .ioWdata(ioWdata), .ioRdata_q(ioRdata_q), .globalIrqEnable(globalIrqEnable),
    .readyIrq(readyIrq), .cpuStall(cpuStall)
);

// ===== test/tb.sv
`timescale 1ns/10ps
`include "eca_defines.svh"
module tb;
    import eca_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, porRst = 1'b1, ioWrite = 1'b0, ioRead = 1'b0;
    logic        globalIrqEnable = 1'b0, programStoreEnable = 1'b0;
    eca_sel_type ioSel = 2'h0;
    logic [7:0]  ioWdata = 8'h00, ioRdata_q, d [2];
    logic        readyIrq, cpuStall, rcClkPin;
    logic [1:0]  rcDiv = 2'h0, rdPipe = 2'h0;
    logic [11:0] a [2];
    logic [15:0] expQ [$], ent;
    int          compares = 0, miscompares = 0, cyc = 0;
    int          stallLen = 0, lastStall = 0;
    eca_top #(.PROG_RC_CYCLES(4)) dut (
        .clk(clk), .rst(rst), .porRst(porRst), .ioWrite(ioWrite), .ioRead(ioRead),
        .ioSel(ioSel), .ioWdata(ioWdata), .ioRdata_q(ioRdata_q),
        .globalIrqEnable(globalIrqEnable), .programStoreEnable(programStoreEnable),
        .readyIrq(readyIrq), .cpuStall(cpuStall), .rcClkPin(rcClkPin)
    );
    always #12.5 clk = ~clk;
    // Oscillator pin at a quarter of the bus clock
    always @(negedge clk) rcDiv <= rcDiv + 2'h1;
    assign rcClkPin = rcDiv[1];
    task automatic final_report();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(string n, logic [7:0] seen, logic [7:0] want);
        compares++;
        if (seen !== want) begin
            miscompares++;
            $display("[FAIL] %s expected %0h seen %0h", n, want, seen);
        end
    endtask
    task automatic wr(eca_sel_type s, logic [7:0] v);
        ioWrite = 1'b1;
        ioSel = s;
        ioWdata = v;
        @(negedge clk);
        ioWrite = 1'b0;
        // At least one idle edge so back-to-back calls never retouch the strobe
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            if (cpuStall !== 1'b1) break;
        end
    endtask
    // Mask zero means poll only, nothing compared
    task automatic rd(eca_sel_type s, logic [7:0] want, logic [7:0] m);
        ioRead = 1'b1;
        ioSel = s;
        expQ.push_back({m, want});
        @(negedge clk);
        ioRead = 1'b0;
        @(negedge clk);
    endtask
    task automatic pollIdle();
        for (int i = 0; i < 80; i++) begin
            rd(`ECA_SEL_CTRL, 8'h00, 8'h00);
            if (ioRdata_q[1] === 1'b0) return;
        end
        check("writeStrobe", 8'h01, 8'h00);
    endtask
    task automatic setAddr(logic [11:0] x);
        wr(`ECA_SEL_ADDR_LO, x[7:0]);
        wr(`ECA_SEL_ADDR_HI, {4'h0, x[11:8]});
    endtask
    task automatic prog(logic [11:0] x, logic [7:0] v);
        logic g;
        g = globalIrqEnable;
        pollIdle();
        globalIrqEnable = 1'b0;
        setAddr(x);
        wr(`ECA_SEL_DATA, v);
        wr(`ECA_SEL_CTRL, 8'h0C);
        wr(`ECA_SEL_CTRL, 8'h0A);
        globalIrqEnable = g;
    endtask
    task automatic fetch(logic [11:0] x, logic [7:0] v);
        setAddr(x);
        wr(`ECA_SEL_CTRL, 8'h09);
        rd(`ECA_SEL_DATA, v, 8'hFF);
        check("cpuStall", 8'(lastStall), 8'h04);
        rd(`ECA_SEL_CTRL, 8'h00, 8'h01);
    endtask
    // ----------------------------------------
    // Monitor: oldest note against settled data
    // ----------------------------------------
    always @(posedge clk) rdPipe <= {rdPipe[0], ioRead};
    // Length of the latest stall run, sampled away from the launching edge
    always @(negedge clk) begin
        if (cpuStall === 1'b1) stallLen <= stallLen + 1;
        else begin
            if (stallLen != 0) lastStall <= stallLen;
            stallLen <= 0;
        end
    end
    always @(negedge clk) begin
        if (rdPipe[1]) begin
            ent = expQ.pop_front();
            if (ent[15:8] != 8'h00) check("ioRdata_q", ioRdata_q & ent[15:8], ent[7:0]);
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            final_report();
        end
    end
    initial begin
        void'($urandom(82));
        repeat (6) @(negedge clk);
        rst = 1'b0;
        porRst = 1'b0;
        rd(`ECA_SEL_ADDR_LO, 8'h00, 8'hFF);
        rd(`ECA_SEL_DATA, 8'h00, 8'hFF);
        wr(`ECA_SEL_CTRL, 8'hF8);
        rd(`ECA_SEL_CTRL, 8'h08, 8'hFF);
        check("readyIrq", {7'h00, readyIrq}, 8'h00);
        globalIrqEnable = 1'b1;
        wr(`ECA_SEL_ADDR_HI, 8'hFF);
        rd(`ECA_SEL_ADDR_HI, 8'h0F, 8'hFF);
        check("readyIrq", {7'h00, readyIrq}, 8'h01);
        for (int i = 0; i < 2; i++) begin
            a[i] = 12'($urandom);
            d[i] = 8'($urandom);
            prog(a[i], d[i]);
            check("readyIrq", {7'h00, readyIrq}, 8'h00);
            rd(`ECA_SEL_CTRL, 8'h02, 8'h02);
            check("cpuStall", 8'(lastStall), 8'h02);
            wr(`ECA_SEL_DATA, ~d[i]);
            wr(`ECA_SEL_ADDR_LO, ~a[i][7:0]);
            wr(`ECA_SEL_CTRL, 8'h09);
            rd(`ECA_SEL_ADDR_LO, a[i][7:0], 8'hFF);
            rd(`ECA_SEL_DATA, ~d[i], 8'hFF);
            pollIdle();
            check("readyIrq", {7'h00, readyIrq}, 8'h01);
            fetch(a[i], d[i]);
        end
        // Strobe outside the window must leave the array alone
        wr(`ECA_SEL_DATA, 8'h5A);
        wr(`ECA_SEL_CTRL, 8'h02);
        rd(`ECA_SEL_CTRL, 8'h00, 8'h02);
        wr(`ECA_SEL_CTRL, 8'h04);
        rd(`ECA_SEL_CTRL, 8'h04, 8'h04);
        repeat (2) @(negedge clk);
        rd(`ECA_SEL_CTRL, 8'h00, 8'h04);
        wr(`ECA_SEL_CTRL, 8'h02);
        rd(`ECA_SEL_CTRL, 8'h00, 8'h02);
        fetch(a[1], d[1]);
        prog(a[0], 8'hA5);
        programStoreEnable = 1'b1;
        repeat (40) @(negedge clk);
        rd(`ECA_SEL_CTRL, 8'h02, 8'h02);
        @(negedge clk);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        rd(`ECA_SEL_CTRL, 8'h02, 8'h02);
        programStoreEnable = 1'b0;
        pollIdle();
        fetch(a[0], 8'hA5);
        repeat (2) @(negedge clk);
        final_report();
    end
endmodule
